/* File: common/wds_pkg.sv */
// Summary of operation
// - interval field codes 00..11 select 2^17, 2^20, 2^23, 2^26 clocks
// - flag set at interval end; irq needs its own enable and global enable
// - when armed, reset follows the flag event by 512 clocks, irq enable irrelevant
// - restart strobe before time-out restarts the interval count from zero
// - restart strobe clears itself; software never writes it back
// - armed and no restart before expiry means the processor is reset
// - watchdog reset sets the reset-cause flag; it stays until software or power-fail clears it
// - counter runs freely; flag still set each interval with reset and irq off
// - flag cleared by software or any reset, never by hardware on its own
// - watchdog reset output lasts two machine cycles
// - slow clock modes count the clock divided by 64 or 1024
// - power-fail disables the watchdog; its own reset only restarts the count
// - bit positions of strobe, arm, cause, flag, interval and irq enable
// - counter fed from system clock through a divider chain; tap sets interval
// - reset generation and interrupt generation are independent of each other
// - clearing reset arm disables resets while the counter keeps running
// - arm, flag and restart writes need the timed-access procedure
// - interval select defaults to the shortest interval after reset
package wds_pkg;

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_CLKDIV = 8'h8E;
  localparam logic [7:0] IDX_WDCTL  = 8'hD8;
  localparam logic [7:0] IDX_EIE    = 8'hE8;
  localparam logic [7:0] IDX_TACC   = 8'hF0;
  localparam logic [7:0] IDX_SYSCTL = 8'hF1;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_MSB = 9;

  // field positions
  localparam int unsigned RESTART_BIT = 0;
  localparam int unsigned ARM_BIT     = 1;
  localparam int unsigned CAUSE_BIT   = 2;
  localparam int unsigned FLAG_BIT    = 3;
  localparam int unsigned IVL_LO_BIT  = 6;
  localparam int unsigned IVL_HI_BIT  = 7;
  localparam int unsigned IRQEN_BIT   = 4;
  localparam int unsigned GIE_BIT     = 7;
  localparam int unsigned PMM_A_BIT   = 0;
  localparam int unsigned PMM_B_BIT   = 1;

  // reset values
  localparam logic [7:0] CLKDIV_RST = 8'h00;
  localparam logic [7:0] EIE_RST    = 8'h00;
  localparam logic [7:0] SYSCTL_RST = 8'h00;

  // counting
  localparam int unsigned CNT_W = 26;
  localparam int unsigned EXP_W = 5;
  localparam logic [9:0] RESET_DELAY = 10'h200;
  localparam logic [9:0] RESET_LAST  = RESET_DELAY - 10'h001;
  localparam logic [1:0] RST_MCYCLES = 2'h2;
  localparam int unsigned DIV_W = 10;
  localparam logic [DIV_W-1:0] DIV_MASK_MC   = 10'h003;
  localparam logic [DIV_W-1:0] DIV_MASK_64   = 10'h03F;
  localparam logic [DIV_W-1:0] DIV_MASK_1024 = 10'h3FF;

  // timed access
  localparam logic [7:0] TA_KEY1   = 8'hAA;
  localparam logic [7:0] TA_KEY2   = 8'h55;
  localparam logic [3:0] TA_WINDOW = 4'h8;

  // bus encodings
  localparam int unsigned HTRANS_ACT_BIT = 1;
  localparam logic [2:0]  HSIZE_WORD     = 3'h2;
  localparam logic        HRESP_OKAY     = 1'b0;

  typedef enum logic [1:0] {PM_FULL, PM_DIV64, PM_DIV1024} wds_pmode_e;
  typedef enum logic [1:0] {ST_RUN, ST_PENDING, ST_RESET} wds_state_e;
  typedef enum logic [1:0] {TA_IDLE, TA_KEYED, TA_OPEN} wds_ta_e;

endpackage : wds_pkg

/* File: hw/wds_divider.sv */
`timescale 1ns/1ps
`default_nettype none

module wds_divider
  import wds_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // rate select
  input  wire wds_pmode_e pmode,
  // one-cycle enables
  output logic            tickEn,
  output logic            mcEn
);

  logic [DIV_W-1:0] divCnt_q;
  logic [DIV_W-1:0] divCnt_d;
  logic             tap64;
  logic             tap1024;
  logic             tapMc;

  // free-running prescaler, never cleared so rates stay phase-stable
  assign divCnt_d = divCnt_q + 1'b1;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_q <= '0;
    end else begin
      divCnt_q <= divCnt_d;
    end
  end

  // taps of the divider chain
  assign tap64   = (divCnt_q & DIV_MASK_64) == DIV_MASK_64;
  assign tap1024 = (divCnt_q & DIV_MASK_1024) == DIV_MASK_1024;
  assign tapMc   = (divCnt_q & DIV_MASK_MC) == DIV_MASK_MC;

  // count source: every clock at full rate, slowed clock in power modes
  assign tickEn = (pmode == PM_DIV1024) ? tap1024 :
                  (pmode == PM_DIV64)   ? tap64 : 1'b1;
  // machine cycle is four clocks at full rate, one slow tick otherwise
  assign mcEn   = (pmode == PM_DIV1024) ? tap1024 :
                  (pmode == PM_DIV64)   ? tap64 : tapMc;

endmodule : wds_divider

`default_nettype wire

/* File: hw/wds_watchdog.sv */
`timescale 1ns/1ps
`default_nettype none

module wds_watchdog
  import wds_pkg::*;
#(
  // interval exponents per select code, may be shortened for simulation
  parameter int unsigned INTERVAL_EXP0 = 17,
  parameter int unsigned INTERVAL_EXP1 = 20,
  parameter int unsigned INTERVAL_EXP2 = 23,
  parameter int unsigned INTERVAL_EXP3 = 26
)(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // supply monitor, asynchronous level
  input  wire logic        powerFailIn,
  // to processor reset and interrupt logic
  output logic             wdResetOut,
  output logic             wdIrqOut
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic              wrPend_q;
  logic [7:0]        wrIdx_q;
  logic [31:0]       hrdata_q;
  logic              hready_q;
  logic              pfSync1_q;
  logic              pfSync2_q;
  logic [7:0]        clkdiv_q;
  logic [7:0]        eie_q;
  logic [7:0]        sysctl_q;
  logic              ewt_q;
  logic              flag_q;
  logic              reset_cause_flag_q;
  logic              ewt_d;
  logic              flag_d;
  logic              reset_cause_flag_d;
  logic [CNT_W-1:0]  cnt_q;
  logic [CNT_W-1:0]  cnt_d;
  logic [9:0]        pend_q;
  logic [9:0]        pend_d;
  logic [1:0]        mcs_q;
  logic [1:0]        mcs_d;
  wds_state_e        st_q;
  wds_state_e        st_d;
  wds_ta_e           ta_q;
  wds_ta_e           ta_d;
  logic [3:0]        taTmr_q;
  logic [3:0]        taTmr_d;
  logic              wdReset_q;
  logic              irq_q;

  logic              addrPhase;
  logic              addrOk;
  logic [7:0]        addrIdx;
  logic [7:0]        wdctlRd;
  logic [7:0]        rdByte;
  logic [7:0]        wrData;
  logic              wrClkdiv;
  logic              wrWdctl;
  logic              wrEie;
  logic              wrTacc;
  logic              wrSysctl;
  logic              taOpen;
  logic              protWr;
  logic              restartPulse;
  logic              pfAct;
  wds_pmode_e        pmodeSel;
  logic              tickEn;
  logic              mcEn;
  logic [1:0]        ivlSel;
  logic [EXP_W-1:0]  selExp;
  logic [CNT_W:0]    maskWide;
  logic [CNT_W-1:0]  ivlMask;
  logic              hit;
  logic              rstEntry;

  // ---------------------------------------------------------------
  // bus address phase decode
  // ---------------------------------------------------------------
  // only whole-word accesses at aligned word addresses map a register
  assign addrPhase = hsel & htrans[HTRANS_ACT_BIT] & hready;
  assign addrIdx   = haddr[IDX_MSB:IDX_LSB];
  assign addrOk    = (haddr[31:IDX_MSB+1] == '0) & (haddr[IDX_LSB-1:0] == '0) & (hsize == HSIZE_WORD);

  // read view of the control register; the restart strobe always reads zero
  assign wdctlRd = (8'(flag_q) << FLAG_BIT) | (8'(reset_cause_flag_q) << CAUSE_BIT) | (8'(ewt_q) << ARM_BIT);

  // read mux, unmapped addresses answer zero with an okay response
  assign rdByte = !addrOk                ? 8'h00 :
                  (addrIdx == IDX_CLKDIV) ? clkdiv_q :
                  (addrIdx == IDX_WDCTL)  ? wdctlRd :
                  (addrIdx == IDX_EIE)    ? eie_q :
                  (addrIdx == IDX_TACC)   ? {7'h00, taOpen} :
                  (addrIdx == IDX_SYSCTL) ? sysctl_q : 8'h00;

  // read data is sampled at the address phase so the slave never waits;
  // the single-transfer master puts idle between transfers, so a read
  // never overlaps the data phase of the write before it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_q <= '0;
      wrPend_q <= 1'b0;
      wrIdx_q  <= '0;
      hready_q <= 1'b1;
    end else begin
      hrdata_q <= (addrPhase && !hwrite) ? {24'h000000, rdByte} : '0;
      wrPend_q <= addrPhase & hwrite & addrOk;
      wrIdx_q  <= addrIdx;
      hready_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // bus data phase: write strobes
  // ---------------------------------------------------------------
  assign wrData   = hwdata[7:0];
  assign wrClkdiv = wrPend_q & (wrIdx_q == IDX_CLKDIV);
  assign wrWdctl  = wrPend_q & (wrIdx_q == IDX_WDCTL);
  assign wrEie    = wrPend_q & (wrIdx_q == IDX_EIE);
  assign wrTacc   = wrPend_q & (wrIdx_q == IDX_TACC);
  assign wrSysctl = wrPend_q & (wrIdx_q == IDX_SYSCTL);

  // protected bits change only inside an open timed-access window
  assign taOpen       = (ta_q == TA_OPEN);
  assign protWr       = wrWdctl & taOpen;
  assign restartPulse = protWr & wrData[RESTART_BIT];

  // ---------------------------------------------------------------
  // timed-access sequencer
  // ---------------------------------------------------------------
  // two keys in order open a short window for one protected write;
  // this keeps errant code from restarting or disarming the watchdog
  always_comb begin
    ta_d    = ta_q;
    taTmr_d = (taTmr_q != 4'h0) ? taTmr_q - 4'h1 : taTmr_q;
    if (wrTacc) begin
      taTmr_d = TA_WINDOW;
      if (wrData == TA_KEY1) begin
        ta_d = TA_KEYED;
      end else if (wrData == TA_KEY2 && ta_q == TA_KEYED) begin
        ta_d = TA_OPEN;
      end else begin
        ta_d = TA_IDLE;
      end
    end else if (protWr || (taTmr_q == 4'h0)) begin
      ta_d = TA_IDLE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ta_q    <= TA_IDLE;
      taTmr_q <= '0;
    end else begin
      ta_q    <= ta_d;
      taTmr_q <= taTmr_d;
    end
  end

  // ---------------------------------------------------------------
  // power-fail synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pfSync1_q <= 1'b0;
      pfSync2_q <= 1'b0;
    end else begin
      pfSync1_q <= powerFailIn;
      pfSync2_q <= pfSync1_q;
    end
  end

  assign pfAct = pfSync2_q;

  // ---------------------------------------------------------------
  // count source
  // ---------------------------------------------------------------
  // mode b takes precedence when both slow modes are set
  assign pmodeSel = sysctl_q[PMM_B_BIT] ? PM_DIV1024 :
                    sysctl_q[PMM_A_BIT] ? PM_DIV64 : PM_FULL;

  wds_divider u_div (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pmode   (pmodeSel),
    .tickEn  (tickEn),
    .mcEn    (mcEn)
  );

  // ---------------------------------------------------------------
  // interval selection and time-out detect
  // ---------------------------------------------------------------
  assign ivlSel   = clkdiv_q[IVL_HI_BIT:IVL_LO_BIT];
  assign selExp   = (ivlSel == 2'h3) ? EXP_W'(INTERVAL_EXP3) :
                    (ivlSel == 2'h2) ? EXP_W'(INTERVAL_EXP2) :
                    (ivlSel == 2'h1) ? EXP_W'(INTERVAL_EXP1) : EXP_W'(INTERVAL_EXP0);
  assign maskWide = ({{CNT_W{1'b0}}, 1'b1} << selExp) - {{CNT_W{1'b0}}, 1'b1};
  assign ivlMask  = maskWide[CNT_W-1:0];

  // one event per interval, on the tick that completes it
  assign hit = tickEn & ((cnt_q & ivlMask) == ivlMask) & (st_q != ST_RESET) & !pfAct;

  // the pending window ran out with the arm still set and no restart
  assign rstEntry = (st_q == ST_PENDING) & tickEn & (pend_q == RESET_LAST)
                  & ewt_q & !restartPulse & !pfAct;

  // ---------------------------------------------------------------
  // interval counter
  // ---------------------------------------------------------------
  // free running: wraps at every interval whatever the enables say
  always_comb begin
    cnt_d = cnt_q;
    if (pfAct || restartPulse || st_q == ST_RESET) begin
      cnt_d = '0;
    end else if (hit) begin
      cnt_d = '0;
    end else if (tickEn) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // reset sequencer
  // ---------------------------------------------------------------
  // armed time-out starts a 512-tick window, then a two machine cycle reset
  always_comb begin
    st_d   = st_q;
    pend_d = pend_q;
    mcs_d  = mcs_q;
    case (st_q)
      ST_RUN: begin
        if (hit && ewt_q) begin
          st_d   = ST_PENDING;
          pend_d = '0;
        end
      end
      ST_PENDING: begin
        if (restartPulse || !ewt_q) begin
          st_d = ST_RUN;
        end else if (rstEntry) begin
          st_d  = ST_RESET;
          mcs_d = '0;
        end else if (tickEn) begin
          pend_d = pend_q + 10'h001;
        end
      end
      ST_RESET: begin
        if (mcEn) begin
          if (mcs_q == RST_MCYCLES - 2'h1) begin
            st_d = ST_RUN;
          end else begin
            mcs_d = mcs_q + 2'h1;
          end
        end
      end
      default: begin
        st_d = ST_RUN;
      end
    endcase
    if (pfAct) begin
      st_d = ST_RUN;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q   <= ST_RUN;
      pend_q <= '0;
      mcs_q  <= '0;
      cnt_q  <= '0;
    end else begin
      st_q   <= st_d;
      pend_q <= pend_d;
      mcs_q  <= mcs_d;
      cnt_q  <= cnt_d;
    end
  end

  // ---------------------------------------------------------------
  // control and status bits
  // ---------------------------------------------------------------
  // the time-out event beats a software clear in the same cycle;
  // the watchdog's own reset clears the flag like any other reset
  assign flag_d = pfAct        ? 1'b0 :
                  hit          ? 1'b1 :
                  rstEntry     ? 1'b0 :
                  protWr       ? wrData[FLAG_BIT] : flag_q;

  // cause flag: set by our reset, cleared only by writing zero or power-fail
  assign reset_cause_flag_d = pfAct        ? 1'b0 :
                  rstEntry     ? 1'b1 :
                  (wrWdctl && !wrData[CAUSE_BIT]) ? 1'b0 : reset_cause_flag_q;

  // arm survives the watchdog's own reset, power-fail clears it
  assign ewt_d  = pfAct        ? 1'b0 :
                  protWr       ? wrData[ARM_BIT] : ewt_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
      reset_cause_flag_q <= 1'b0;
      ewt_q  <= 1'b0;
    end else begin
      flag_q <= flag_d;
      reset_cause_flag_q <= reset_cause_flag_d;
      ewt_q  <= ewt_d;
    end
  end

  // unprotected registers, written freely
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clkdiv_q <= CLKDIV_RST;
      eie_q    <= EIE_RST;
      sysctl_q <= SYSCTL_RST;
    end else begin
      if (wrClkdiv) clkdiv_q <= wrData;
      if (wrEie)    eie_q    <= wrData;
      if (wrSysctl) sysctl_q <= wrData;
    end
  end

  // ---------------------------------------------------------------
  // outputs to processor reset and interrupt logic
  // ---------------------------------------------------------------
  // reset and interrupt paths share only the flag event, never each other
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdReset_q <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      wdReset_q <= (st_d == ST_RESET);
      irq_q     <= flag_q & eie_q[IRQEN_BIT] & sysctl_q[GIE_BIT];
    end
  end

  assign wdResetOut = wdReset_q;
  assign wdIrqOut   = irq_q;
  assign hrdata     = hrdata_q;
  assign hreadyout  = hready_q;
  assign hresp      = HRESP_OKAY;

endmodule : wds_watchdog

`default_nettype wire

/* File: bench/wds_watchdog_props.sv */
`timescale 1ns/1ps
`default_nettype none

module wds_watchdog_props
  import wds_pkg::*;
#(
  parameter int unsigned INTERVAL_EXP0 = 17
)(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // supply and watchdog outputs
  input wire logic        powerFailIn,
  input wire logic        wdResetOut,
  input wire logic        wdIrqOut
);
  localparam int MIN_GAP = (1 << INTERVAL_EXP0) + 500;
  logic        rdPend_q;
  logic [15:0] highCnt_q;
  logic [15:0] gapCnt_q;

  // gap counts from reset release too: any reset restarts the watchdog count
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdPend_q  <= 1'b0;
      highCnt_q <= 16'h0000;
      gapCnt_q  <= 16'h0000;
    end else begin
      rdPend_q  <= hsel & htrans[1] & hready & !hwrite;
      highCnt_q <= wdResetOut ? highCnt_q + 16'h0001 : 16'h0000;
      gapCnt_q  <= wdResetOut ? 16'h0000 : (gapCnt_q == 16'hFFFF ? gapCnt_q : gapCnt_q + 16'h0001);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_ready_always: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (hresp == HRESP_OKAY) else $error("hresp not okay");
  a_rdata_idle: assert property (!rdPend_q |-> hrdata == 32'h0) else $error("hrdata outside data phase");
  a_rst_min: assert property ($rose(wdResetOut) |=> wdResetOut [*4]) else $error("reset pulse short");
  a_rst_max: assert property (highCnt_q <= 16'h0800) else $error("reset pulse long");
  a_rst_gap: assert property ($rose(wdResetOut) |-> gapCnt_q >= MIN_GAP) else $error("count not restarted");
  a_pf_no_rst: assert property (powerFailIn [*4] |-> !wdResetOut) else $error("reset in power fail");
  a_pf_no_irq: assert property (powerFailIn [*5] |-> !wdIrqOut) else $error("irq in power fail");
  a_irq_rst_clr: assert property (wdResetOut [*3] |-> !wdIrqOut) else $error("flag kept over reset");
endmodule : wds_watchdog_props

bind wds_watchdog wds_watchdog_props #(.INTERVAL_EXP0(INTERVAL_EXP0)) u_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .powerFailIn(powerFailIn),
  .wdResetOut(wdResetOut), .wdIrqOut(wdIrqOut));

`default_nettype wire

/* File: bench/wds_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none

module wds_cpu_model (
  // clock and reset
  input  wire logic   sys_clk,
  input  wire logic   rst_n,
  // watchdog reset request
  input  wire logic   wdResetOut,
  // observations for the bench
  output logic [7:0]  resetCount,
  output logic [15:0] lastWidth
);
  logic [15:0] width_q;

  // the processor sits in reset while the request is high; a pulse counts once it ends
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      width_q    <= 16'h0000;
      resetCount <= 8'h00;
      lastWidth  <= 16'h0000;
    end else if (wdResetOut) begin
      width_q <= width_q + 16'h0001;
    end else if (width_q != 16'h0000) begin
      resetCount <= resetCount + 8'h01;
      lastWidth  <= width_q;
      width_q    <= 16'h0000;
    end
  end
endmodule : wds_cpu_model

`default_nettype wire

/* File: bench/watchdog_supervisor_timer_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; $display("BAD %0t got %h exp %h", $time, g, e); end end

module watchdog_supervisor_timer_tb_top
  import wds_pkg::*;
;
  // shortened interval exponents keep the run brief
  localparam int EXPS [4] = '{6, 10, 11, 12};
  logic        sys_clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        powerFailIn;
  logic        wdResetOut;
  logic        wdIrqOut;
  logic [7:0]  resetCount;
  logic [15:0] lastWidth;
  logic [7:0]  rd;
  int          miscompares;
  int          checks;
  int          cyc;
  int          t0;
  int          n;
  int          e;

  wds_watchdog #(.INTERVAL_EXP0(EXPS[0]), .INTERVAL_EXP1(EXPS[1]), .INTERVAL_EXP2(EXPS[2]),
    .INTERVAL_EXP3(EXPS[3])) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .powerFailIn(powerFailIn), .wdResetOut(wdResetOut), .wdIrqOut(wdIrqOut));

  wds_cpu_model i_cpu (
    .sys_clk(sys_clk), .rst_n(rst_n), .wdResetOut(wdResetOut), .resetCount(resetCount), .lastWidth(lastWidth));

  // clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // the whole sequence needs about 28000 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report

  // one single transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {22'h0, idx, 2'h0};
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata[7:0];
  endtask : bus

  // protected write behind the two keys
  task automatic ta(input logic [7:0] idx, input logic [7:0] wd);
    bus(1'b1, IDX_TACC, TA_KEY1);
    bus(1'b1, IDX_TACC, TA_KEY2);
    bus(1'b1, idx, wd);
  endtask : ta

  // cycles from the restart edge until software sees the flag
  task automatic poll_flag();
    t0 = int'($time);
    rd = 8'h00;
    while (rd[FLAG_BIT] !== 1'b1) bus(1'b0, IDX_WDCTL, 8'h00);
    n = (int'($time) - t0) / 4;
  endtask : poll_flag

  initial begin
    rst_n = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = HSIZE_WORD; hwdata = 32'h0; powerFailIn = 1'b0;
    miscompares = 0; checks = 0; cyc = 0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, i == 0 ? IDX_CLKDIV : i == 1 ? IDX_WDCTL : i == 2 ? IDX_EIE : 8'h10, 8'h00);
      `CHK(rd, 8'h00)
    end
    $display("test reset values done");
    bus(1'b1, IDX_WDCTL, 8'h02);
    bus(1'b0, IDX_WDCTL, 8'h00);
    `CHK(rd, 8'h00)
    bus(1'b1, IDX_TACC, TA_KEY1);
    bus(1'b1, IDX_TACC, TA_KEY2);
    repeat (12) @(posedge sys_clk);
    bus(1'b1, IDX_WDCTL, 8'h02);
    bus(1'b0, IDX_WDCTL, 8'h00);
    `CHK(rd, 8'h00)
    $display("test protected writes done");
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, IDX_CLKDIV, {c[1:0], 6'h00});
      ta(IDX_WDCTL, 8'h01);
      poll_flag();
      e = 1 << EXPS[c];
      `CHK(n >= e && n <= e + 6, 1'b1)
    end
    repeat (100) @(posedge sys_clk);
    bus(1'b0, IDX_WDCTL, 8'h00);
    `CHK(rd[FLAG_BIT], 1'b1)
    bus(1'b0, IDX_CLKDIV, 8'h00);
    `CHK(rd, 8'hC0)
    $display("test intervals done");
    bus(1'b1, IDX_CLKDIV, 8'h00);
    bus(1'b1, IDX_EIE, 8'h10);
    ta(IDX_WDCTL, 8'h01);
    repeat (80) @(posedge sys_clk);
    `CHK(wdIrqOut, 1'b0)
    bus(1'b1, IDX_SYSCTL, 8'h80);
    repeat (2) @(posedge sys_clk);
    `CHK(wdIrqOut, 1'b1)
    `CHK(resetCount, 8'h00)
    ta(IDX_WDCTL, 8'h01);
    repeat (2) @(posedge sys_clk);
    `CHK(wdIrqOut, 1'b0)
    // enables stay on so the reset and power-fail checks see the interrupt drop
    $display("test interrupt done");
    bus(1'b1, IDX_CLKDIV, 8'h40);
    ta(IDX_WDCTL, 8'h01);
    t0 = int'($time);
    ta(IDX_WDCTL, 8'h02);
    while (wdResetOut !== 1'b1) @(posedge sys_clk);
    n = (int'($time) - t0) / 4;
    e = (1 << EXPS[1]) + int'(RESET_DELAY);
    `CHK(n >= e && n <= e + 4, 1'b1)
    while (resetCount !== 8'h01) @(posedge sys_clk);
    `CHK(wdIrqOut, 1'b0)
    `CHK(lastWidth >= 16'd5 && lastWidth <= 16'd8, 1'b1)
    bus(1'b0, IDX_WDCTL, 8'h00);
    `CHK(rd, 8'h06)
    bus(1'b1, IDX_WDCTL, 8'h00);
    bus(1'b0, IDX_WDCTL, 8'h00);
    `CHK(rd, 8'h02)
    for (int i = 0; i < 3; i++) begin
      repeat (900) @(posedge sys_clk);
      ta(IDX_WDCTL, 8'h03);
    end
    bus(1'b0, IDX_WDCTL, 8'h00);
    `CHK(rd, 8'h02)
    `CHK(resetCount, 8'h01)
    ta(IDX_WDCTL, 8'h00);
    repeat (2000) @(posedge sys_clk);
    `CHK(resetCount, 8'h01)
    bus(1'b0, IDX_WDCTL, 8'h00);
    `CHK(rd[FLAG_BIT], 1'b1)
    $display("test watchdog reset done");
    ta(IDX_WDCTL, 8'h0A);
    repeat (2) @(posedge sys_clk);
    `CHK(wdIrqOut, 1'b1)
    powerFailIn <= 1'b1;
    repeat (5) @(posedge sys_clk);
    powerFailIn <= 1'b0;
    bus(1'b0, IDX_WDCTL, 8'h00);
    `CHK(rd, 8'h00)
    `CHK(wdIrqOut, 1'b0)
    repeat (1700) @(posedge sys_clk);
    `CHK(resetCount, 8'h01)
    $display("test power fail done");
    bus(1'b1, IDX_CLKDIV, 8'h00);
    bus(1'b1, IDX_SYSCTL, 8'h01);
    ta(IDX_WDCTL, 8'h01);
    poll_flag();
    e = (1 << EXPS[0]) * 64;
    `CHK(n >= e - 64 && n <= e + 70, 1'b1)
    bus(1'b1, IDX_SYSCTL, 8'h03);
    ta(IDX_WDCTL, 8'h01);
    repeat (8000) @(posedge sys_clk);
    bus(1'b0, IDX_WDCTL, 8'h00);
    `CHK(rd[FLAG_BIT], 1'b0)
    $display("test slow modes done");
    final_report();
  end
endmodule : watchdog_supervisor_timer_tb_top

`default_nettype wire
